//--- sag_addr_gen.sv
// top of the segment address generator: offset pick, physical sum, checks
`timescale 1ns/1ns
`default_nettype none
module sag_addr_gen
    import sag_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        req_valid,
    input  wire sag_acc_t    acc_kind,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  modrm,
    input  wire logic [7:0]  disp_lo,
    input  wire logic [7:0]  disp_hi,
    input  wire logic        ovr_valid,
    input  wire sag_seg_t    ovr_seg,
    input  wire logic [15:0] code_segment_base,
    input  wire logic [15:0] stack_segment_base,
    input  wire logic [15:0] first_data_segment_base,
    input  wire logic [15:0] second_data_segment_base,
    input  wire logic [15:0] fetch_pointer,
    input  wire logic [15:0] stack_pointer,
    input  wire logic [15:0] base_pointer,
    input  wire logic [15:0] base_word,
    input  wire logic [15:0] source_index,
    input  wire logic [15:0] destination_index,
    output logic             out_valid,
    output logic [19:0]      phys_addr,
    output logic [15:0]      operand_offset,
    output sag_seg_t         seg_sel,
    output logic             reg_operand,
    output logic             float_nop
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  out_valid;
        logic                  float_nop;
        logic                  reg_operand;
        sag_seg_t              seg;
        logic [SAG_OFS_W-1:0]  offset;
        logic [SAG_PHYS_W-1:0] phys;
    } sag_state_t;

    sag_state_t  st_r;
    sag_state_t  st_nxt;
    logic [15:0] ea_w;
    logic        bp_based_w;
    logic        reg_mode_w;
    sag_seg_t    seg_w;
    logic [15:0] seg_base_w;
    logic [15:0] ofs_w;
    logic        is_esc_w;

    // ------------------------------------------------------------
    // offset calculation and segment choice
    // ------------------------------------------------------------
    // mode byte decode and three-term sum
    sag_ea_calc u_ea (
        .modrm             (modrm),
        .disp_lo           (disp_lo),
        .disp_hi           (disp_hi),
        .base_word         (base_word),
        .base_pointer      (base_pointer),
        .source_index      (source_index),
        .destination_index (destination_index),
        .ea                (ea_w),
        .bp_based          (bp_based_w),
        .reg_mode          (reg_mode_w)
    );

    // default segments and prefix handling
    sag_seg_sel u_seg (
        .acc_kind                 (acc_kind),
        .bp_based                 (bp_based_w),
        .ovr_valid                (ovr_valid),
        .ovr_seg                  (ovr_seg),
        .code_segment_base        (code_segment_base),
        .stack_segment_base       (stack_segment_base),
        .first_data_segment_base  (first_data_segment_base),
        .second_data_segment_base (second_data_segment_base),
        .seg                      (seg_w),
        .seg_base                 (seg_base_w)
    );

    // the float escape is caught before any address is formed
    assign is_esc_w = (opcode == SAG_FLOAT_ESC_OP);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // offset source follows the access kind
    always_comb begin
        case (acc_kind)
            SAG_ACC_FETCH: ofs_w = fetch_pointer;
            SAG_ACC_STACK: ofs_w = stack_pointer;
            SAG_ACC_SRC_A: ofs_w = source_index;
            SAG_ACC_DST_B: ofs_w = destination_index;
            default:       ofs_w = ea_w;
        endcase
    end

    // one request gives one answer on the next edge; a request that
    // is a no-op or a register operand produces no memory address
    always_comb begin
        st_nxt             = st_r;
        st_nxt.out_valid   = 1'b0;
        st_nxt.float_nop   = 1'b0;
        st_nxt.reg_operand = 1'b0;
        if (req_valid) begin
            if (is_esc_w) begin
                st_nxt.float_nop = 1'b1;
            end else if ((acc_kind == SAG_ACC_EA) && reg_mode_w) begin
                st_nxt.reg_operand = 1'b1;
            end else begin
                st_nxt.out_valid = 1'b1;
                st_nxt.seg       = seg_w;
                st_nxt.offset    = ofs_w;
                // unsigned paragraph plus offset, carry past bit 19 lost
                st_nxt.phys      = 20'({seg_base_w, 4'h0} + {4'h0, ofs_w});
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    assign out_valid      = st_r.out_valid;
    assign phys_addr      = st_r.phys;
    assign operand_offset = st_r.offset;
    assign seg_sel        = st_r.seg;
    assign reg_operand    = st_r.reg_operand;
    assign float_nop      = st_r.float_nop;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // a memory request that is neither escape nor register form
    logic mem_req_w;
    assign mem_req_w = req_valid && !is_esc_w && !((acc_kind == SAG_ACC_EA) && reg_mode_w);

    a_fetch_code: assert property (
        mem_req_w && acc_kind == SAG_ACC_FETCH |=> out_valid && seg_sel == SAG_SEG_CODE
    ) else $error("fetch did not use code segment");

    a_fetch_ofs: assert property (
        mem_req_w && acc_kind == SAG_ACC_FETCH |=> operand_offset == $past(fetch_pointer)
    ) else $error("fetch offset is not fetch pointer");

    a_stack_fixed: assert property (
        mem_req_w && acc_kind == SAG_ACC_STACK
        |=> seg_sel == SAG_SEG_STACK && operand_offset == $past(stack_pointer)
    ) else $error("stack access not stack based");

    a_dst_fixed: assert property (
        mem_req_w && acc_kind == SAG_ACC_DST_B
        |=> seg_sel == SAG_SEG_DATA1 && operand_offset == $past(destination_index)
    ) else $error("group b destination misplaced");

    a_src_default: assert property (
        mem_req_w && acc_kind == SAG_ACC_SRC_A && !ovr_valid
        |=> seg_sel == SAG_SEG_DATA0 && operand_offset == $past(source_index)
    ) else $error("group a source misplaced");

    a_ovr_taken: assert property (
        mem_req_w && ovr_valid && (acc_kind == SAG_ACC_EA || acc_kind == SAG_ACC_SRC_A)
        |=> seg_sel == $past(ovr_seg)
    ) else $error("override prefix not applied");

    a_code_ovr: assert property (
        mem_req_w && ovr_valid && ovr_seg == SAG_SEG_CODE && acc_kind == SAG_ACC_SRC_A
        |=> seg_sel == SAG_SEG_CODE ##1 (!out_valid || !$past(ovr_valid) || seg_sel == $past(seg_w))
    ) else $error("code override lost");

    a_data1_ovr: assert property (
        mem_req_w && ovr_valid && ovr_seg == SAG_SEG_DATA1 && acc_kind == SAG_ACC_EA
        |=> seg_sel == SAG_SEG_DATA1
    ) else $error("second data override lost");

    a_bp_default: assert property (
        mem_req_w && acc_kind == SAG_ACC_EA && !ovr_valid
        && modrm[SAG_MOD_HI:SAG_MOD_LO] == SAG_MOD_DISP8 && modrm[SAG_RM_HI:SAG_RM_LO] == 3'h6
        |=> seg_sel == SAG_SEG_STACK
    ) else $error("base pointer form not on stack");

    a_nonbp_default: assert property (
        mem_req_w && acc_kind == SAG_ACC_EA && !ovr_valid && modrm[SAG_RM_HI:SAG_RM_LO] == 3'h7
        |=> seg_sel == SAG_SEG_DATA0
    ) else $error("plain form not on first data");

    a_data0_ovr: assert property (
        mem_req_w && acc_kind == SAG_ACC_EA && ovr_valid && ovr_seg == SAG_SEG_DATA0 && bp_based_w
        |=> seg_sel == SAG_SEG_DATA0
    ) else $error("first data override ignored");

    a_ea_sum: assert property (
        mem_req_w && acc_kind == SAG_ACC_EA
        && modrm[SAG_MOD_HI:SAG_MOD_LO] == SAG_MOD_DISP16 && modrm[SAG_RM_HI:SAG_RM_LO] == 3'h2
        |=> operand_offset == $past(16'(base_pointer + source_index + {disp_hi, disp_lo}))
    ) else $error("three term sum wrong");

    a_disp8_sext: assert property (
        mem_req_w && acc_kind == SAG_ACC_EA
        && modrm[SAG_MOD_HI:SAG_MOD_LO] == SAG_MOD_DISP8 && modrm[SAG_RM_HI:SAG_RM_LO] == 3'h7
        |=> operand_offset == $past(16'(base_word + {{8{disp_lo[7]}}, disp_lo}))
    ) else $error("short displacement not sign extended");

    a_direct_ofs: assert property (
        mem_req_w && acc_kind == SAG_ACC_EA
        && modrm[SAG_MOD_HI:SAG_MOD_LO] == SAG_MOD_NODISP && modrm[SAG_RM_HI:SAG_RM_LO] == 3'h6
        |=> operand_offset == $past({disp_hi, disp_lo}) && seg_sel != SAG_SEG_STACK
            || $past(ovr_valid)
    ) else $error("direct offset wrong");

    a_reg_mode: assert property (
        req_valid && !is_esc_w && acc_kind == SAG_ACC_EA
        && modrm[SAG_MOD_HI:SAG_MOD_LO] == SAG_MOD_REG
        |=> reg_operand && !out_valid
    ) else $error("register form made an address");

    a_phys_sum: assert property (
        mem_req_w |=> phys_addr == $past(20'({seg_base_w, 4'h0} + {4'h0, ofs_w}))
    ) else $error("physical address sum wrong");

    a_phys_para: assert property (
        mem_req_w && acc_kind == SAG_ACC_FETCH && fetch_pointer == 16'h0000
        |=> phys_addr[3:0] == 4'h0 && phys_addr[19:4] == $past(code_segment_base)
    ) else $error("segment not on paragraph");

    a_float_nop: assert property (
        req_valid && is_esc_w |=> float_nop && !out_valid && !reg_operand
    ) else $error("float escape had an effect");

    a_idle_quiet: assert property (
        !req_valid |=> !out_valid && !float_nop && !reg_operand
    ) else $error("answer without request");

    a_hold_addr: assert property (
        !req_valid |=> $stable(phys_addr) && $stable(operand_offset)
    ) else $error("address moved while idle");

endmodule : sag_addr_gen
`default_nettype wire

//--- sag_bcu_model.sv
// bus control unit model: consumes the physical addresses the generator hands over
`timescale 1ns/1ns
`default_nettype none
module sag_bcu_model
    import sag_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        out_valid,
    input  wire logic [19:0] phys_addr,
    output logic      [15:0] n_addr,
    output logic      [19:0] last_addr
);
    // --------------------------------------------------------
    // capture
    // --------------------------------------------------------
    // cleared with the generator, so both sides restart their tally together after a reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            n_addr    <= 16'h0;
            last_addr <= 20'h0;
        end else if (out_valid) begin
            n_addr    <= n_addr + 16'h1;
            last_addr <= phys_addr;
        end
    end
endmodule : sag_bcu_model
`default_nettype wire

//--- sag_ea_calc.sv
// operand offset calculation from the second instruction byte
`timescale 1ns/1ns
`default_nettype none
module sag_ea_calc
    import sag_pkg::*;
(
    input  wire logic [7:0]  modrm,
    input  wire logic [7:0]  disp_lo,
    input  wire logic [7:0]  disp_hi,
    input  wire logic [15:0] base_word,
    input  wire logic [15:0] base_pointer,
    input  wire logic [15:0] source_index,
    input  wire logic [15:0] destination_index,
    output logic      [15:0] ea,
    output logic             bp_based,
    output logic             reg_mode
);
    logic [1:0]  mode;
    logic [2:0]  rm;
    logic [15:0] disp;
    logic [15:0] base;
    logic [15:0] index;

    // field split of the mode byte
    assign mode = modrm[SAG_MOD_HI:SAG_MOD_LO];
    assign rm   = modrm[SAG_RM_HI:SAG_RM_LO];
    assign reg_mode = (mode == SAG_MOD_REG);

    // displacement, base and index each optional
    always_comb begin
        disp     = 16'h0000;
        base     = 16'h0000;
        index    = 16'h0000;
        bp_based = 1'b0;
        case (mode)
            SAG_MOD_NODISP: disp = (rm == SAG_RM_DIRECT) ? {disp_hi, disp_lo} : 16'h0000;
            SAG_MOD_DISP8:  disp = {{8{disp_lo[7]}}, disp_lo};
            SAG_MOD_DISP16: disp = {disp_hi, disp_lo};
            default:        disp = 16'h0000;
        endcase
        case (rm)
            3'h0: begin base = base_word;    index = source_index;      end
            3'h1: begin base = base_word;    index = destination_index; end
            3'h2: begin base = base_pointer; index = source_index;      end
            3'h3: begin base = base_pointer; index = destination_index; end
            3'h4: index = source_index;
            3'h5: index = destination_index;
            3'h6: base = (mode == SAG_MOD_NODISP) ? 16'h0000 : base_pointer;
            default: base = base_word;
        endcase
        bp_based = (rm == 3'h2) || (rm == 3'h3) || ((rm == SAG_RM_DIRECT) && (mode != SAG_MOD_NODISP));
        // carry out of bit 15 is dropped: offsets wrap inside the segment
        ea = 16'(disp + base + index);
    end
endmodule : sag_ea_calc
`default_nettype wire

//--- sag_pkg.sv
// shared constants and types of the segment address generator
package sag_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SAG_OFS_W   = 16;  // offsets are unsigned 16-bit
    localparam int SAG_PHYS_W  = 20;  // physical bus is 1 Mbyte
    localparam int SAG_SEG_SHL = 4;   // segment paragraph of 16 bytes

    // ------------------------------------------------------------
    // second-byte (mode/rm) field layout and encodings
    // ------------------------------------------------------------
    localparam int         SAG_MOD_HI     = 7;
    localparam int         SAG_MOD_LO     = 6;
    localparam int         SAG_RM_HI      = 2;
    localparam int         SAG_RM_LO      = 0;
    localparam logic [1:0] SAG_MOD_NODISP = 2'h0;
    localparam logic [1:0] SAG_MOD_DISP8  = 2'h1;
    localparam logic [1:0] SAG_MOD_DISP16 = 2'h2;
    localparam logic [1:0] SAG_MOD_REG    = 2'h3;
    localparam logic [2:0] SAG_RM_DIRECT  = 3'h6;

    // opcode that decodes as the first float escape (plain default)
    localparam logic [7:0] SAG_FLOAT_ESC_OP = 8'hd8;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SAG_ACC_FETCH = 3'h0,
        SAG_ACC_STACK = 3'h1,
        SAG_ACC_EA    = 3'h2,
        SAG_ACC_SRC_A = 3'h3,
        SAG_ACC_DST_B = 3'h4
    } sag_acc_t;

    typedef enum logic [1:0] {
        SAG_SEG_CODE  = 2'h0,
        SAG_SEG_STACK = 2'h1,
        SAG_SEG_DATA0 = 2'h2,
        SAG_SEG_DATA1 = 2'h3
    } sag_seg_t;

endpackage : sag_pkg

//--- sag_seg_sel.sv
// segment choice by access kind and override prefix
`timescale 1ns/1ns
`default_nettype none
module sag_seg_sel
    import sag_pkg::*;
(
    input  wire sag_acc_t    acc_kind,
    input  wire logic        bp_based,
    input  wire logic        ovr_valid,
    input  wire sag_seg_t    ovr_seg,
    input  wire logic [15:0] code_segment_base,
    input  wire logic [15:0] stack_segment_base,
    input  wire logic [15:0] first_data_segment_base,
    input  wire logic [15:0] second_data_segment_base,
    output sag_seg_t         seg,
    output logic      [15:0] seg_base
);
    // fixed kinds ignore any prefix; the others take it for this access
    always_comb begin
        case (acc_kind)
            SAG_ACC_FETCH: seg = SAG_SEG_CODE;
            SAG_ACC_STACK: seg = SAG_SEG_STACK;
            SAG_ACC_DST_B: seg = SAG_SEG_DATA1;
            SAG_ACC_SRC_A: seg = ovr_valid ? ovr_seg : SAG_SEG_DATA0;
            SAG_ACC_EA:    seg = ovr_valid ? ovr_seg : (bp_based ? SAG_SEG_STACK : SAG_SEG_DATA0);
            default:       seg = SAG_SEG_DATA0;
        endcase
        case (seg)
            SAG_SEG_CODE:  seg_base = code_segment_base;
            SAG_SEG_STACK: seg_base = stack_segment_base;
            SAG_SEG_DATA0: seg_base = first_data_segment_base;
            default:       seg_base = second_data_segment_base;
        endcase
    end
endmodule : sag_seg_sel
`default_nettype wire

//--- tb_segment_address_generator.sv
// self-checking testbench of the segment address generator
`timescale 1ns/1ns
`default_nettype none
module tb_segment_address_generator
    import sag_pkg::*;
;

    // --------------------------------------------------------
    // row of stimulus beside its expected answer (ans: 0 mem, 1 reg, 2 escape, 3 none)
    // --------------------------------------------------------
    typedef struct {
        sag_acc_t    acc;
        logic        esc;
        logic [7:0]  modrm;
        logic [15:0] disp;
        logic        ov;
        sag_seg_t    os;
        logic [15:0] p;
        logic [15:0] bp;
        logic [15:0] bw;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [1:0]  ans;
        sag_seg_t    seg;
        logic [15:0] off;
    } sag_row_t;

    localparam int NROW = 20;

    logic        core_clk = 1'b0;
    logic        arst_n;
    logic        req_valid;
    sag_acc_t    acc_kind;
    logic [7:0]  opcode;
    logic [7:0]  modrm;
    logic [7:0]  disp_lo;
    logic [7:0]  disp_hi;
    logic        ovr_valid;
    sag_seg_t    ovr_seg;
    logic [15:0] code_segment_base;
    logic [15:0] stack_segment_base;
    logic [15:0] first_data_segment_base;
    logic [15:0] second_data_segment_base;
    logic [15:0] fetch_pointer;
    logic [15:0] stack_pointer;
    logic [15:0] base_pointer;
    logic [15:0] base_word;
    logic [15:0] source_index;
    logic [15:0] destination_index;
    logic        out_valid;
    logic [19:0] phys_addr;
    logic [15:0] operand_offset;
    sag_seg_t    seg_sel;
    logic        reg_operand;
    logic        float_nop;
    logic [15:0] n_addr;
    logic [19:0] bcu_last;
    logic [15:0] b_cs = 16'h1000;
    logic [15:0] b_ss = 16'h2000;
    logic [15:0] b_d0 = 16'h3000;
    logic [15:0] b_d1 = 16'h4000;
    sag_seg_t    last_seg;
    logic [15:0] last_off;
    logic [19:0] last_phys;
    logic [15:0] mem_cnt = 16'h0;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    sag_row_t    rows [NROW];
    sag_row_t    idle;
    sag_row_t    cr;

    always #5 core_clk = ~core_clk;

    sag_addr_gen i_dut (.core_clk(core_clk), .arst_n(arst_n), .req_valid(req_valid), .acc_kind(acc_kind),
        .opcode(opcode), .modrm(modrm), .disp_lo(disp_lo), .disp_hi(disp_hi), .ovr_valid(ovr_valid),
        .ovr_seg(ovr_seg), .code_segment_base(code_segment_base), .stack_segment_base(stack_segment_base),
        .first_data_segment_base(first_data_segment_base), .second_data_segment_base(second_data_segment_base),
        .fetch_pointer(fetch_pointer), .stack_pointer(stack_pointer), .base_pointer(base_pointer),
        .base_word(base_word), .source_index(source_index), .destination_index(destination_index),
        .out_valid(out_valid), .phys_addr(phys_addr), .operand_offset(operand_offset), .seg_sel(seg_sel),
        .reg_operand(reg_operand), .float_nop(float_nop));

    sag_bcu_model i_bcu (.core_clk(core_clk), .arst_n(arst_n), .out_valid(out_valid), .phys_addr(phys_addr),
        .n_addr(n_addr), .last_addr(bcu_last));

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    // expected physical address; 20-bit result drops any carry
    function automatic logic [19:0] exp_phys(input sag_seg_t s, input logic [15:0] o);
        logic [15:0] b;
        case (s)
            SAG_SEG_CODE:  b = b_cs;
            SAG_SEG_STACK: b = b_ss;
            SAG_SEG_DATA0: b = b_d0;
            default:       b = b_d1;
        endcase
        return {b, 4'h0} + {4'h0, o};
    endfunction : exp_phys

    task automatic chk(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    // drive one request at a rising edge; bases come from the b_ variables
    task automatic apply(input sag_row_t r, input logic v);
        req_valid                <= v;
        acc_kind                 <= r.acc;
        opcode                   <= r.esc ? SAG_FLOAT_ESC_OP : 8'h8b;
        modrm                    <= r.modrm;
        disp_lo                  <= r.disp[7:0];
        disp_hi                  <= r.disp[15:8];
        ovr_valid                <= r.ov;
        ovr_seg                  <= r.os;
        fetch_pointer            <= r.p;
        stack_pointer            <= r.p;
        base_pointer             <= r.bp;
        base_word                <= r.bw;
        source_index             <= r.ix;
        destination_index        <= r.iy;
        code_segment_base        <= b_cs;
        stack_segment_base       <= b_ss;
        first_data_segment_base  <= b_d0;
        second_data_segment_base <= b_d1;
    endtask : apply

    // one cycle after a request: the right pulse, and data updated or held
    task automatic check(input sag_row_t r);
        chk(out_valid === (r.ans == 2'h0), "memory answer pulse");
        chk(reg_operand === (r.ans == 2'h1), "register form pulse");
        chk(float_nop === (r.ans == 2'h2), "escape pulse");
        if (r.ans == 2'h0) begin
            last_seg  = r.seg;
            last_off  = r.off;
            last_phys = exp_phys(r.seg, r.off);
            mem_cnt++;
        end
        chk(seg_sel === last_seg, "segment choice");
        chk(operand_offset === last_off, "operand offset");
        chk(phys_addr === last_phys, "physical address");
    endtask : check

    task automatic reset_check();
        chk(out_valid === 1'b0 && reg_operand === 1'b0 && float_nop === 1'b0, "pulse in reset");
        chk(phys_addr === 20'h0 && operand_offset === 16'h0 && seg_sel === SAG_SEG_CODE, "data in reset");
        last_seg  = SAG_SEG_CODE;
        last_off  = 16'h0;
        last_phys = 20'h0;
        mem_cnt   = 16'h0;
    endtask : reset_check

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // --------------------------------------------------------
    // stimulus table: ovr ignored on fetch, stack and group B destination
    // --------------------------------------------------------
    initial begin
        rows[0]  = '{SAG_ACC_FETCH, 0, 8'h00, 16'h0, 1, SAG_SEG_DATA0, 16'h0100, 0, 0, 0, 0, 0, SAG_SEG_CODE, 16'h0100};
        rows[1]  = '{SAG_ACC_STACK, 0, 8'h00, 16'h0, 1, SAG_SEG_DATA1, 16'h00fe, 0, 0, 0, 0, 0, SAG_SEG_STACK, 16'h00fe};
        rows[2]  = '{SAG_ACC_DST_B, 0, 8'h00, 16'h0, 1, SAG_SEG_CODE, 0, 0, 0, 0, 16'h0020, 0, SAG_SEG_DATA1, 16'h0020};
        rows[3]  = '{SAG_ACC_SRC_A, 0, 8'h00, 16'h0, 0, SAG_SEG_CODE, 0, 0, 0, 16'h0030, 0, 0, SAG_SEG_DATA0, 16'h0030};
        rows[4]  = '{SAG_ACC_SRC_A, 0, 8'h00, 16'h0, 1, SAG_SEG_CODE, 0, 0, 0, 16'h0030, 0, 0, SAG_SEG_CODE, 16'h0030};
        rows[5]  = '{SAG_ACC_SRC_A, 0, 8'h00, 16'h0, 1, SAG_SEG_DATA1, 0, 0, 0, 16'h0030, 0, 0, SAG_SEG_DATA1, 16'h0030};
        rows[6]  = '{SAG_ACC_SRC_A, 0, 8'h00, 16'h0, 1, SAG_SEG_STACK, 0, 0, 0, 16'h0030, 0, 0, SAG_SEG_STACK, 16'h0030};
        rows[7]  = '{SAG_ACC_EA, 0, 8'h46, 16'h00fe, 0, SAG_SEG_CODE, 0, 16'h0010, 0, 0, 0, 0, SAG_SEG_STACK, 16'h000e};
        rows[8]  = '{SAG_ACC_EA, 0, 8'h46, 16'h00fe, 1, SAG_SEG_DATA0, 0, 16'h0010, 0, 0, 0, 0, SAG_SEG_DATA0, 16'h000e};
        rows[9]  = '{SAG_ACC_EA, 0, 8'h00, 16'h0, 0, SAG_SEG_CODE, 0, 0, 16'h0100, 16'h0030, 0, 0, SAG_SEG_DATA0, 16'h0130};
        rows[10] = '{SAG_ACC_EA, 0, 8'h80, 16'h1234, 0, SAG_SEG_CODE, 0, 0, 16'h0100, 16'h0030, 0, 0, SAG_SEG_DATA0, 16'h1364};
        rows[11] = '{SAG_ACC_EA, 0, 8'h06, 16'hbeef, 0, SAG_SEG_CODE, 0, 0, 0, 0, 0, 0, SAG_SEG_DATA0, 16'hbeef};
        rows[12] = '{SAG_ACC_EA, 0, 8'h82, 16'h0001, 0, SAG_SEG_CODE, 0, 16'hffff, 0, 16'h0002, 0, 0, SAG_SEG_STACK, 16'h0002};
        rows[13] = '{SAG_ACC_EA, 0, 8'h01, 16'h0, 1, SAG_SEG_DATA1, 0, 0, 0, 0, 16'h0005, 0, SAG_SEG_DATA1, 16'h0005};
        rows[14] = '{SAG_ACC_EA, 0, 8'hc0, 16'h0, 0, SAG_SEG_CODE, 0, 0, 0, 0, 0, 1, SAG_SEG_CODE, 16'h0};
        rows[15] = '{SAG_ACC_FETCH, 1, 8'h00, 16'h0, 0, SAG_SEG_CODE, 16'h0200, 0, 0, 0, 0, 2, SAG_SEG_CODE, 16'h0};
        rows[16] = '{SAG_ACC_EA, 0, 8'h47, 16'h0080, 0, SAG_SEG_CODE, 0, 0, 16'h0100, 0, 0, 0, SAG_SEG_DATA0, 16'h0080};
        rows[17] = '{SAG_ACC_EA, 0, 8'h00, 16'h0, 1, SAG_SEG_CODE, 0, 0, 16'h0100, 16'h0030, 0, 0, SAG_SEG_CODE, 16'h0130};
        rows[18] = '{SAG_ACC_EA, 0, 8'h06, 16'h0010, 1, SAG_SEG_STACK, 0, 0, 0, 0, 0, 0, SAG_SEG_STACK, 16'h0010};
        rows[19] = '{SAG_ACC_FETCH, 0, 8'h00, 16'h0, 0, SAG_SEG_CODE, 16'h0, 0, 0, 0, 0, 0, SAG_SEG_CODE, 16'h0};
        idle     = '{SAG_ACC_FETCH, 0, 8'h00, 16'h0, 0, SAG_SEG_CODE, 0, 0, 0, 0, 0, 3, SAG_SEG_CODE, 16'h0};
        cr       = '{SAG_ACC_FETCH, 0, 8'h00, 16'h0, 0, SAG_SEG_CODE, 16'hfff0, 0, 0, 0, 0, 0, SAG_SEG_CODE, 16'hfff0};
    end

    // --------------------------------------------------------
    // main sequence: reset, table back to back, then awkward cases
    // --------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        apply(idle, 1'b0);
        repeat (20) @(posedge core_clk);
        @(negedge core_clk) reset_check();
        @(posedge core_clk) arst_n <= 1'b1;
        @(negedge core_clk) reset_check();
        // each edge takes a new row while the previous row's answer is checked
        for (int i = 0; i <= NROW; i++) begin
            @(posedge core_clk);
            if (i < NROW)
                apply(rows[i], 1'b1);
            else
                apply(idle, 1'b0);
            @(negedge core_clk);
            if (i > 0)
                check(rows[i - 1]);
        end
        @(negedge core_clk) check(idle);
        // top of the code segment: the carry out of 20 bits must vanish
        b_cs = 16'hffff;
        @(posedge core_clk) apply(cr, 1'b1);
        @(posedge core_clk) apply(idle, 1'b0);
        @(negedge core_clk) check(cr);
        chk(phys_addr === 20'h0ffe0, "carry dropped");
        // the bus unit takes an answer one edge after it appears
        @(negedge core_clk) chk(n_addr === mem_cnt && bcu_last === last_phys, "bus unit before reset");
        // reset in mid-run clears everything, then the first request is served
        @(posedge core_clk) arst_n <= 1'b0;
        @(negedge core_clk) reset_check();
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk) reset_check();
        @(posedge core_clk) apply(rows[9], 1'b1);
        @(posedge core_clk) apply(idle, 1'b0);
        @(negedge core_clk) check(rows[9]);
        @(negedge core_clk) chk(n_addr === mem_cnt && bcu_last === last_phys, "answers seen by bus unit");
        conclude();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
endmodule : tb_segment_address_generator
`default_nettype wire
